/* rtl/php_pkg.sv */
// shared constants and state types of the parallel handshake port
package php_pkg;

  // ************************************************************
  // widths and lane numbering
  // ************************************************************
  localparam int unsigned DATA_W    = 16;
  localparam int unsigned LANES     = 3;
  localparam int unsigned IRQ_W     = 7;
  localparam int unsigned LANE_LOW  = 0;
  localparam int unsigned LANE_HIGH = 1;
  localparam int unsigned LANE_WORD = 2;

  // ************************************************************
  // location offsets within the port block
  // ************************************************************
  localparam logic [1:0] ADDR_HIGH_DATA = 2'h0;
  localparam logic [1:0] ADDR_LOW_DATA  = 2'h1;
  localparam logic [1:0] ADDR_STATUS    = 2'h2;
  localparam logic [1:0] ADDR_MASK      = 2'h3;

  // ************************************************************
  // field positions of the control word
  // ************************************************************
  localparam int unsigned BIT_OE_LOWER12 = 15;
  localparam int unsigned BIT_OE_UPPER4  = 14;
  localparam int unsigned BIT_OUT_FREE0  = 11;
  localparam int unsigned BIT_IN_PRES0   = 8;
  localparam int unsigned STAT_OE_LOWER  = 7;
  localparam int unsigned STAT_OE_UPPER  = 6;
  localparam int unsigned LOWER_DRIVE_W  = 12;
  localparam int unsigned REROUTE_W      = 4;

  // ************************************************************
  // values after reset, and synchroniser depth
  // ************************************************************
  localparam logic [6:0]  MASK_RESET     = 7'h7f;
  localparam logic        OE_RESET       = 1'b0;
  localparam logic [15:0] DATA_RESET     = 16'h0000;
  localparam int unsigned SYNC_STAGES    = 3;

  // ************************************************************
  // handshake state machines, one-hot
  // ************************************************************
  typedef enum logic [2:0] {
    OUT_FREE  = 3'b001,
    OUT_READY = 3'b010,
    OUT_DRAIN = 3'b100
  } out_state_t;

  typedef enum logic [2:0] {
    IN_EMPTY   = 3'b001,
    IN_PRESENT = 3'b010,
    IN_ACKED   = 3'b100
  } in_state_t;

endpackage

/* rtl/pin_sync.sv */
// three-stage pin synchroniser with second/third stage agreement
`timescale 1ns/1ps
module pin_sync #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clock,  // core clock
  input  wire logic             rst_b,  // async reset, active low
  input  wire logic [WIDTH-1:0] raw,    // asynchronous pin levels
  output logic      [WIDTH-1:0] clean   // settled levels
);

  // ************************************************************
  // stages
  // ************************************************************
  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] mid_ff;
  logic [WIDTH-1:0] late_ff;
  logic [WIDTH-1:0] clean_ff;
  logic [WIDTH-1:0] nxt_clean;

  // a bit only moves once stages two and three agree, so a single
  // sampling glitch never reaches the handshake logic
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      nxt_clean[i] = (mid_ff[i] == late_ff[i]) ? late_ff[i] : clean_ff[i];
    end
  end

  // meta_ff feeds mid_ff and nothing else
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      meta_ff  <= '0;
      mid_ff   <= '0;
      late_ff  <= '0;
      clean_ff <= '0;
    end else begin
      meta_ff  <= raw;
      mid_ff   <= meta_ff;
      late_ff  <= mid_ff;
      clean_ff <= nxt_clean;
    end
  end

  assign clean = clean_ff;

endmodule

/* rtl/parallel_handshake_port.sv */
// programmed 16-bit parallel output and input port with ready/ack handshakes
`timescale 1ns/1ps
module parallel_handshake_port (
  input  wire logic        clock,                 // core clock, 200 MHz
  input  wire logic        rst_b,                 // async reset, active low
  input  wire logic        cpu_wr,                // write cycle end, one-cycle pulse
  input  wire logic        cpu_rd,                // read cycle end, one-cycle pulse
  input  wire logic [1:0]  cpu_addr,              // location offset
  input  wire logic        cpu_word,              // 16-bit access
  input  wire logic [15:0] cpu_wdata,             // write data, byte in [7:0]
  output logic      [15:0] cpu_rdata,             // read data, registered
  output logic             cpu_rd_valid,          // read data valid pulse
  output logic      [15:0] out_data,              // output connector data, true
  output logic      [15:0] out_data_b,            // output connector data, complement
  output logic      [15:0] out_data_oe,           // output driver enables
  input  wire logic [3:0]  out_pin_in,            // top four output lines as seen, true
  input  wire logic [3:0]  out_pin_in_b,          // top four output lines, complement
  output logic             out_ready_low_byte,    // low byte ready, true
  output logic             out_ready_low_byte_b,  // low byte ready, complement
  output logic             out_ready_high_byte,   // high byte ready, true
  output logic             out_ready_high_byte_b, // high byte ready, complement
  output logic             out_ready_word,        // word ready, true
  output logic             out_ready_word_b,      // word ready, complement
  input  wire logic        out_ack_low_byte,      // low byte ack, true
  input  wire logic        out_ack_low_byte_b,    // low byte ack, complement
  input  wire logic        out_ack_high_byte,     // high byte ack, true
  input  wire logic        out_ack_high_byte_b,   // high byte ack, complement
  input  wire logic        out_ack_word,          // word ack, true
  input  wire logic        out_ack_word_b,        // word ack, complement
  input  wire logic [15:0] in_data,               // input connector data, true
  input  wire logic [15:0] in_data_b,             // input connector data, complement
  input  wire logic        in_ready_low_byte,     // low byte ready, true
  input  wire logic        in_ready_low_byte_b,   // low byte ready, complement
  input  wire logic        in_ready_high_byte,    // high byte ready, true
  input  wire logic        in_ready_high_byte_b,  // high byte ready, complement
  input  wire logic        in_ready_word,         // word ready, true
  input  wire logic        in_ready_word_b,       // word ready, complement
  output logic             in_ack_low_byte,       // low byte ack, true
  output logic             in_ack_low_byte_b,     // low byte ack, complement
  output logic             in_ack_high_byte,      // high byte ack, true
  output logic             in_ack_high_byte_b,    // high byte ack, complement
  output logic             in_ack_word,           // word ack, true
  output logic             in_ack_word_b,         // word ack, complement
  input  wire logic        input_reroute_jumper,  // reroute strap
  input  wire logic        dma_done_src,          // transfer done source level
  output logic      [6:0]  irq_request,           // unmasked request levels
  output logic      [15:0] port_control_word      // live control word view
);

  // ************************************************************
  // access decode
  // ************************************************************
  // one-hot lane of a data access; word only at the high offset
  function automatic logic [2:0] lane_of(input logic [1:0] addr, input logic word);
    logic [2:0] sel;
    sel = 3'h0;
    if (word) begin
      if (addr == php_pkg::ADDR_HIGH_DATA) sel[php_pkg::LANE_WORD] = 1'b1;
    end else if (addr == php_pkg::ADDR_HIGH_DATA) begin
      sel[php_pkg::LANE_HIGH] = 1'b1;
    end else if (addr == php_pkg::ADDR_LOW_DATA) begin
      sel[php_pkg::LANE_LOW] = 1'b1;
    end
    return sel;
  endfunction

  logic [2:0] wr_lane;
  logic [2:0] rd_lane;
  logic       ctl_access;

  assign wr_lane    = cpu_wr ? lane_of(cpu_addr, cpu_word) : 3'h0;
  assign rd_lane    = cpu_rd ? lane_of(cpu_addr, cpu_word) : 3'h0;
  assign ctl_access = cpu_word && (cpu_addr == php_pkg::ADDR_STATUS);

  // ************************************************************
  // receivers: true and complement must agree, then synchronise
  // ************************************************************
  logic [2:0]  ack_rx;
  logic [2:0]  rdy_rx;
  logic [15:0] din_rx;
  logic [3:0]  top_rx;
  logic [26:0] raw_bus;
  logic [26:0] clean_bus;
  logic [2:0]  ack_s;
  logic [2:0]  rdy_s;
  logic [15:0] din_s;
  logic [3:0]  top_s;
  logic        jumper_s;

  // a line counts as asserted only while its complement is low
  assign ack_rx  = {out_ack_word & ~out_ack_word_b, out_ack_high_byte & ~out_ack_high_byte_b,
                    out_ack_low_byte & ~out_ack_low_byte_b};
  assign rdy_rx  = {in_ready_word & ~in_ready_word_b, in_ready_high_byte & ~in_ready_high_byte_b,
                    in_ready_low_byte & ~in_ready_low_byte_b};
  assign din_rx  = in_data & ~in_data_b;
  assign top_rx  = out_pin_in & ~out_pin_in_b;
  assign raw_bus = {input_reroute_jumper, top_rx, din_rx, rdy_rx, ack_rx};

  pin_sync #(
    .WIDTH (27)
  ) u_sync (
    .clock (clock),
    .rst_b (rst_b),
    .raw   (raw_bus),
    .clean (clean_bus)
  );

  assign ack_s    = clean_bus[2:0];
  assign rdy_s    = clean_bus[5:3];
  assign din_s    = clean_bus[21:6];
  assign top_s    = clean_bus[25:22];
  assign jumper_s = clean_bus[26];

  // ************************************************************
  // output side: latch and per-lane ready handshake
  // ************************************************************
  php_pkg::out_state_t out_st_ff [3];
  php_pkg::out_state_t nxt_out_st [3];
  logic [15:0]         dout_ff;
  logic [15:0]         nxt_dout;
  logic [2:0]          out_free;
  logic [2:0]          out_strobe;

  // a write to a lane still in flight is dropped whole, so that lane's own
  // writes never change the lines under its pending strobe
  always_comb begin
    nxt_dout = dout_ff;
    for (int l = 0; l < 3; l++) begin
      nxt_out_st[l] = out_st_ff[l];
      case (out_st_ff[l])
        php_pkg::OUT_FREE: begin
          if (wr_lane[l]) nxt_out_st[l] = php_pkg::OUT_READY;
        end
        php_pkg::OUT_READY: begin
          if (ack_s[l]) nxt_out_st[l] = php_pkg::OUT_DRAIN;
        end
        php_pkg::OUT_DRAIN: begin
          if (!ack_s[l]) nxt_out_st[l] = php_pkg::OUT_FREE;
        end
        default: nxt_out_st[l] = php_pkg::OUT_FREE;
      endcase
    end
    if (wr_lane[php_pkg::LANE_WORD] && out_free[php_pkg::LANE_WORD]) begin
      nxt_dout = cpu_wdata;
    end else if (wr_lane[php_pkg::LANE_HIGH] && out_free[php_pkg::LANE_HIGH]) begin
      nxt_dout[15:8] = cpu_wdata[7:0];
    end else if (wr_lane[php_pkg::LANE_LOW] && out_free[php_pkg::LANE_LOW]) begin
      nxt_dout[7:0] = cpu_wdata[7:0];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int l = 0; l < 3; l++) out_st_ff[l] <= php_pkg::OUT_FREE;
      dout_ff <= php_pkg::DATA_RESET;
    end else begin
      for (int l = 0; l < 3; l++) out_st_ff[l] <= nxt_out_st[l];
      dout_ff <= nxt_dout;
    end
  end

  generate
    for (genvar g = 0; g < 3; g++) begin : g_out_lane
      assign out_free[g]   = (out_st_ff[g] == php_pkg::OUT_FREE);
      assign out_strobe[g] = (out_st_ff[g] == php_pkg::OUT_READY);
    end
  endgenerate

  // ************************************************************
  // input side: per-lane present / acknowledge handshake
  // ************************************************************
  php_pkg::in_state_t in_st_ff [3];
  php_pkg::in_state_t nxt_in_st [3];
  logic [2:0]         in_present;
  logic [2:0]         in_acked;

  // a read of an empty lane returns the lines but raises no ack
  always_comb begin
    for (int l = 0; l < 3; l++) begin
      nxt_in_st[l] = in_st_ff[l];
      case (in_st_ff[l])
        php_pkg::IN_EMPTY: begin
          if (rdy_s[l]) nxt_in_st[l] = php_pkg::IN_PRESENT;
        end
        php_pkg::IN_PRESENT: begin
          if (rd_lane[l]) nxt_in_st[l] = php_pkg::IN_ACKED;
          else if (!rdy_s[l]) nxt_in_st[l] = php_pkg::IN_EMPTY;
        end
        php_pkg::IN_ACKED: begin
          if (!rdy_s[l]) nxt_in_st[l] = php_pkg::IN_EMPTY;
        end
        default: nxt_in_st[l] = php_pkg::IN_EMPTY;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      for (int l = 0; l < 3; l++) in_st_ff[l] <= php_pkg::IN_EMPTY;
    end else begin
      for (int l = 0; l < 3; l++) in_st_ff[l] <= nxt_in_st[l];
    end
  end

  generate
    for (genvar g = 0; g < 3; g++) begin : g_in_lane
      assign in_present[g] = (in_st_ff[g] == php_pkg::IN_PRESENT);
      assign in_acked[g]   = (in_st_ff[g] == php_pkg::IN_ACKED);
    end
  endgenerate

  // ************************************************************
  // control word: enables, mask and read path
  // ************************************************************
  logic        oe_lower_ff;
  logic        oe_upper_ff;
  logic [6:0]  mask_ff;
  logic [15:0] rdata_ff;
  logic        rvalid_ff;
  logic        nxt_oe_lower;
  logic        nxt_oe_upper;
  logic [6:0]  nxt_mask;
  logic [15:0] nxt_rdata;
  logic [15:0] in_word;
  logic [7:0]  status_byte;

  // rerouting only swaps the low nibble source; without the jumper
  // the top output lines are never looked at
  assign in_word = jumper_s ? {din_s[15:4], top_s} : din_s;

  assign status_byte = {oe_lower_ff, oe_upper_ff, out_free, in_present};

  always_comb begin
    nxt_oe_lower = oe_lower_ff;
    nxt_oe_upper = oe_upper_ff;
    nxt_mask     = mask_ff;
    nxt_rdata    = rdata_ff;
    // only the two enables of the status byte take a write
    if (cpu_wr && ctl_access) begin
      nxt_oe_lower = cpu_wdata[php_pkg::BIT_OE_LOWER12];
      nxt_oe_upper = cpu_wdata[php_pkg::BIT_OE_UPPER4];
      nxt_mask     = cpu_wdata[6:0];
    end else if (cpu_wr && !cpu_word && cpu_addr == php_pkg::ADDR_STATUS) begin
      nxt_oe_lower = cpu_wdata[php_pkg::STAT_OE_LOWER];
      nxt_oe_upper = cpu_wdata[php_pkg::STAT_OE_UPPER];
    end else if (cpu_wr && !cpu_word && cpu_addr == php_pkg::ADDR_MASK) begin
      nxt_mask = cpu_wdata[6:0];
    end
    if (cpu_rd) begin
      nxt_rdata = 16'h0000;
      if (rd_lane[php_pkg::LANE_WORD]) nxt_rdata = in_word;
      else if (rd_lane[php_pkg::LANE_HIGH]) nxt_rdata[7:0] = in_word[15:8];
      else if (rd_lane[php_pkg::LANE_LOW]) nxt_rdata[7:0] = in_word[7:0];
      else if (ctl_access) nxt_rdata = {status_byte, 1'b0, mask_ff};
      else if (cpu_addr == php_pkg::ADDR_STATUS) nxt_rdata[7:0] = status_byte;
      else if (cpu_addr == php_pkg::ADDR_MASK) nxt_rdata[7:0] = {1'b0, mask_ff};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      oe_lower_ff <= php_pkg::OE_RESET;
      oe_upper_ff <= php_pkg::OE_RESET;
      mask_ff     <= php_pkg::MASK_RESET;
      rdata_ff    <= php_pkg::DATA_RESET;
      rvalid_ff   <= 1'b0;
    end else begin
      oe_lower_ff <= nxt_oe_lower;
      oe_upper_ff <= nxt_oe_upper;
      mask_ff     <= nxt_mask;
      rdata_ff    <= nxt_rdata;
      rvalid_ff   <= cpu_rd;
    end
  end

  // ************************************************************
  // pins, requests and views
  // ************************************************************
  // drivers stay off after reset until software enables them
  assign out_data_oe = {{4{oe_upper_ff}}, {12{oe_lower_ff}}};
  assign out_data    = dout_ff;
  assign out_data_b  = ~dout_ff;
  assign out_ready_low_byte    = out_strobe[php_pkg::LANE_LOW];
  assign out_ready_low_byte_b  = ~out_strobe[php_pkg::LANE_LOW];
  assign out_ready_high_byte   = out_strobe[php_pkg::LANE_HIGH];
  assign out_ready_high_byte_b = ~out_strobe[php_pkg::LANE_HIGH];
  assign out_ready_word        = out_strobe[php_pkg::LANE_WORD];
  assign out_ready_word_b      = ~out_strobe[php_pkg::LANE_WORD];
  assign in_ack_low_byte       = in_acked[php_pkg::LANE_LOW];
  assign in_ack_low_byte_b     = ~in_acked[php_pkg::LANE_LOW];
  assign in_ack_high_byte      = in_acked[php_pkg::LANE_HIGH];
  assign in_ack_high_byte_b    = ~in_acked[php_pkg::LANE_HIGH];
  assign in_ack_word           = in_acked[php_pkg::LANE_WORD];
  assign in_ack_word_b         = ~in_acked[php_pkg::LANE_WORD];
  assign irq_request  = {in_present, out_free, dma_done_src} & ~mask_ff;
  assign port_control_word = {status_byte, 1'b0, mask_ff};
  assign cpu_rdata    = rdata_ff;
  assign cpu_rd_valid = rvalid_ff;

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_high_write;
    cpu_wr && !cpu_word && cpu_addr == php_pkg::ADDR_HIGH_DATA && out_free[1];
  endsequence
  sequence s_high_done;
    out_ready_high_byte && out_data[15:8] == $past(cpu_wdata[7:0]);
  endsequence
  property p_high_latch;
    s_high_write |=> s_high_done;
  endproperty
  a_high_latch: assert property (p_high_latch) else $error("high byte not latched");

  property p_one_strobe;
    $onehot0({$rose(out_ready_low_byte), $rose(out_ready_high_byte), $rose(out_ready_word)});
  endproperty
  a_one_strobe: assert property (p_one_strobe) else $error("two strobes at once");

  property p_strobe_hold;
    out_ready_word && !ack_s[2] |=> out_ready_word;
  endproperty
  a_strobe_hold: assert property (p_strobe_hold) else $error("word strobe dropped");

  property p_free_after_ack;
    $rose(out_free[0]) |-> !ack_s[0] && $past(out_st_ff[0]) == php_pkg::OUT_DRAIN;
  endproperty
  a_free_after_ack: assert property (p_free_after_ack) else $error("free set early");

  property p_read_ack;
    cpu_rd && !cpu_word && cpu_addr == php_pkg::ADDR_LOW_DATA && in_present[0]
      |=> in_ack_low_byte && !port_control_word[php_pkg::BIT_IN_PRES0];
  endproperty
  a_read_ack: assert property (p_read_ack) else $error("no ack after read");

  // a status write with the upper enable clear must float the top lines
  property p_upper_float;
    cpu_wr && !cpu_word && cpu_addr == php_pkg::ADDR_STATUS && !cpu_wdata[php_pkg::STAT_OE_UPPER]
      |=> out_data_oe[15:12] == 4'h0;
  endproperty
  a_upper_float: assert property (p_upper_float) else $error("upper drivers on");

  property p_reroute;
    cpu_rd && cpu_word && cpu_addr == php_pkg::ADDR_HIGH_DATA && jumper_s
      |=> cpu_rdata[3:0] == $past(top_s);
  endproperty
  a_reroute: assert property (p_reroute) else $error("reroute source wrong");

  property p_complement;
    out_data_b == ~out_data && out_ready_word_b == !out_ready_word;
  endproperty
  a_complement: assert property (p_complement) else $error("complement wrong");

  property p_mask;
    mask_ff[4] |-> !irq_request[4];
  endproperty
  a_mask: assert property (p_mask) else $error("masked request seen");

  property p_lower_enable;
    cpu_wr && !cpu_word && cpu_addr == php_pkg::ADDR_STATUS
      |=> out_data_oe[11:0] == {12{$past(cpu_wdata[php_pkg::STAT_OE_LOWER])}};
  endproperty
  a_lower_enable: assert property (p_lower_enable) else $error("lower enable wrong");

  property p_stay_clear;
    in_acked[2] && rdy_s[2] |=> !in_present[2];
  endproperty
  a_stay_clear: assert property (p_stay_clear) else $error("present reset early");

endmodule

/* dv/user_device.sv */
// far-side device model: acks output strobes, sends input lanes
`timescale 1ns/1ps
module user_device (
  input  wire logic        clock,  // core clock
  input  wire logic        rst_b,  // async reset, active low
  input  wire logic        slow,   // late acks
  input  wire logic [2:0]  rdy,    // out ready low/high/word
  output logic      [2:0]  ack,    // out ack low/high/word
  input  wire logic        go,     // start an input transfer
  input  wire logic [1:0]  lane,   // lane to send on
  input  wire logic [15:0] val,    // value to send
  input  wire logic [2:0]  in_ack, // input acks seen
  output logic      [2:0]  in_rdy, // input ready low/high/word
  output logic      [15:0] data    // input data lines
);
  logic [7:0][2:0] pipe_ff;
  logic            pend_ff;
  // ack follows its strobe late, so it also drops only after the strobe
  assign ack = slow ? pipe_ff[7] : pipe_ff[0];
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pipe_ff <= '0;
      pend_ff <= 1'b0;
      in_rdy  <= 3'b000;
      data    <= 16'h0000;
    end else begin
      pipe_ff <= {pipe_ff[6:0], rdy};
      if (go) begin
        data    <= val;
        pend_ff <= 1'b1;
      end else if (pend_ff) begin
        in_rdy[lane] <= 1'b1;
        pend_ff      <= 1'b0;
      end else if (|(in_ack & in_rdy)) begin
        in_rdy <= 3'b000;
        data   <= ~data;
      end
    end
  end
endmodule

/* dv/tb_parallel_handshake_port.sv */
// self-checking bench of the parallel handshake port
`timescale 1ns/1ps
module tb_parallel_handshake_port;
  logic        clock, rst_b, cpu_wr, cpu_rd, cpu_word, rd_valid, slow, go, jumper, dma;
  logic [1:0]  cpu_addr, lane;
  logic [15:0] cpu_wdata, rdata, out_data, out_data_b, oe, in_data, pcw, val, exp, sent;
  logic [15:0] sent_q [$];
  logic [3:0]  pin;
  logic [2:0]  ordy, ordy_b, oack, irdy, iack, iack_b;
  logic [6:0]  irq;
  int          err_count, samples_checked, lfsr, n;

  parallel_handshake_port dut (.clock(clock), .rst_b(rst_b), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd),
    .cpu_addr(cpu_addr), .cpu_word(cpu_word), .cpu_wdata(cpu_wdata), .cpu_rdata(rdata),
    .cpu_rd_valid(rd_valid), .out_data(out_data), .out_data_b(out_data_b), .out_data_oe(oe),
    .out_pin_in(pin), .out_pin_in_b(~pin), .out_ready_low_byte(ordy[0]),
    .out_ready_low_byte_b(ordy_b[0]), .out_ready_high_byte(ordy[1]),
    .out_ready_high_byte_b(ordy_b[1]), .out_ready_word(ordy[2]), .out_ready_word_b(ordy_b[2]),
    .out_ack_low_byte(oack[0]), .out_ack_low_byte_b(~oack[0]), .out_ack_high_byte(oack[1]),
    .out_ack_high_byte_b(~oack[1]), .out_ack_word(oack[2]), .out_ack_word_b(~oack[2]),
    .in_data(in_data), .in_data_b(~in_data), .in_ready_low_byte(irdy[0]),
    .in_ready_low_byte_b(~irdy[0]), .in_ready_high_byte(irdy[1]),
    .in_ready_high_byte_b(~irdy[1]), .in_ready_word(irdy[2]), .in_ready_word_b(~irdy[2]),
    .in_ack_low_byte(iack[0]), .in_ack_low_byte_b(iack_b[0]), .in_ack_high_byte(iack[1]),
    .in_ack_high_byte_b(iack_b[1]), .in_ack_word(iack[2]), .in_ack_word_b(iack_b[2]),
    .input_reroute_jumper(jumper), .dma_done_src(dma), .irq_request(irq),
    .port_control_word(pcw));

  user_device far (.clock(clock), .rst_b(rst_b), .slow(slow), .rdy(ordy), .ack(oack),
    .go(go), .lane(lane), .val(val), .in_ack(iack), .in_rdy(irdy), .data(in_data));

  // ****************************************
  // helpers
  // ****************************************
  function automatic int nxt_rand(int s);
    return int'({s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]});
  endfunction

  task automatic chk(logic [15:0] seen, logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask

  // one cpu access; returns just after the edge where its effect lands
  task automatic cpu(logic wr, logic [1:0] a, logic w, logic [15:0] d);
    @(posedge clock);
    cpu_wr    <= wr;
    cpu_rd    <= !wr;
    cpu_addr  <= a;
    cpu_word  <= w;
    cpu_wdata <= d;
    @(posedge clock);
    cpu_wr <= 1'b0;
    cpu_rd <= 1'b0;
    #1;
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // watchdog: the full sequence needs well under 2000 cycles
  initial begin
    #20000;
    err_count++;
    wrap_up();
  end

  initial begin
    {rst_b, cpu_wr, cpu_rd, cpu_word, slow, go, jumper} = '0;
    {cpu_addr, lane, cpu_wdata, val} = '0;
    dma  = 1'b1;
    lfsr = 13;
    pin  = 4'h5;
    exp  = 16'h0000;
    repeat (16) @(posedge clock);
    rst_b <= 1'b1;
    cpu(1'b1, 2'h2, 1'b0, 16'h00c0);
    chk(oe, 16'hffff);
    chk(16'(irq), 16'h0000);
    cpu(1'b1, 2'h3, 1'b0, 16'h0000);
    chk(16'(irq), 16'h000f);
    // output lanes: low, high (slow ack), word
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt_rand(lfsr);
      slow <= (i == 1);
      cpu(1'b1, (i == 0) ? 2'h1 : 2'h0, i == 2, lfsr[15:0]);
      if (i == 0) exp[7:0] = lfsr[7:0];
      else if (i == 1) exp[15:8] = lfsr[7:0];
      else exp = lfsr[15:0];
      chk(out_data, exp);
      chk(out_data_b, ~exp);
      chk(16'(ordy), 16'(1 << i));
      cpu(1'b1, (i == 0) ? 2'h1 : 2'h0, i == 2, ~lfsr[15:0]);
      chk(out_data, exp);
      chk(16'(ordy), 16'(1 << i));
      for (n = 0; n < 60 && ordy[i]; n++) begin @(posedge clock); #1; end
      chk(16'(pcw[11+i]), 16'h0000);
      for (n = 0; n < 30 && !pcw[11+i]; n++) begin @(posedge clock); #1; end
      chk(16'({pcw[11+i], oack[i]}), 16'h0002);
      chk(16'({ordy, ordy_b}), 16'h0007);
    end
    cpu(1'b1, 2'h2, 1'b0, 16'h0080);
    chk(oe, 16'h0fff);
    // input lanes, word read with the reroute strap fitted
    for (int i = 0; i < 3; i++) begin
      lfsr = nxt_rand(lfsr);
      lane   <= i[1:0];
      val    <= lfsr[15:0];
      go     <= 1'b1;
      sent_q.push_back(lfsr[15:0]);
      @(posedge clock);
      go     <= 1'b0;
      jumper <= (i == 2);
      for (n = 0; n < 30 && !pcw[8+i]; n++) begin @(posedge clock); #1; end
      chk(16'(pcw[8+i]), 16'h0001);
      cpu(1'b0, (i == 0) ? 2'h1 : 2'h0, i == 2, 16'h0000);
      sent = sent_q.pop_front();
      exp = (i == 0) ? {8'h00, sent[7:0]} : (i == 1) ? {8'h00, sent[15:8]} : {sent[15:4], pin};
      chk(16'(rd_valid), 16'h0001);
      chk(rdata, exp);
      chk(16'(iack), 16'(1 << i));
      chk(16'(pcw[8+i]), 16'h0000);
      for (n = 0; n < 30 && iack[i]; n++) begin @(posedge clock); #1; end
      chk(16'({iack, iack_b}), 16'h0007);
    end
    wrap_up();
  end
endmodule
